// ==== hdl/xmrs_exec.sv ====
//
// Contract
// - memory rotate right, bit 0 into 7
// - rotate right into working register, no flags
// - rotate through carry to memory, carry only
// - rotate through carry into working register
// - working minus memory minus inverted carry
// - same difference written back to memory
// - carry clear if negative, else set
// - subtract updates all six arithmetic flags
// - decrement memory, skip next when zero
// - skip costs a dummy second cycle
// - decrement into working register, skip if zero
// - set all bits of byte to ones
// - set only the selected bit
// - increment memory, skip next when zero
// - increment into working register, skip if zero
module xmrs_exec (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // operation request
  input wire logic op_valid_in,
  input wire xmrs_pkg::xmrs_op_t op_code_in,
  input wire logic [xmrs_pkg::XMRS_DATA_W-1:0] mem_data_in,
  input wire logic [xmrs_pkg::XMRS_BIT_W-1:0] bit_sel_in,
  input wire logic set_single_in,
  // direct working register load
  input wire logic work_load_in,
  input wire logic [xmrs_pkg::XMRS_DATA_W-1:0] work_data_in,
  // direct status load
  input wire logic flag_load_in,
  input wire logic carry_data_in,
  input wire logic zero_data_in,
  input wire logic nibble_carry_data_in,
  input wire logic signed_range_data_in,
  input wire logic signed_carry_data_in,
  input wire logic chained_null_data_in,
  // issue handshake
  output logic op_ready_out,
  output logic done_out,
  output logic skip_out,
  // data memory write-back
  output logic mem_wr_out,
  output logic [xmrs_pkg::XMRS_DATA_W-1:0] mem_wdata_out,
  // working register and status
  output logic [xmrs_pkg::XMRS_DATA_W-1:0] working_register_out,
  output logic carry_out,
  output logic zero_out,
  output logic nibble_carry_out,
  output logic signed_range_out,
  output logic signed_carry_out,
  output logic chained_null_out
);
  import xmrs_pkg::*;

  // one-step wrap, zero test stays on eight bits
  function automatic logic [XMRS_DATA_W-1:0] step_byte(
    input logic [XMRS_DATA_W-1:0] value,
    input logic up
  );
    step_byte = up ? value + XMRS_ONE : value - XMRS_ONE;
  endfunction

  function automatic logic [XMRS_DATA_W-1:0] set_byte(
    input logic [XMRS_DATA_W-1:0] value,
    input logic [XMRS_BIT_W-1:0] idx,
    input logic single
  );
    set_byte = single ? (value | (XMRS_ONE << idx)) : XMRS_ALL_ONES;
  endfunction

  // state
  xmrs_state_t state_q, state_d;
  logic ready_q, ready_d;
  logic done_q;
  logic skip_q;
  logic mem_wr_q;
  logic [XMRS_DATA_W-1:0] mem_wdata_q;
  logic [XMRS_DATA_W-1:0] work_q, work_d;
  logic carry_q, carry_d;
  logic zero_q, zero_d;
  logic nib_q, nib_d;
  logic ovf_q, ovf_d;
  logic sc_q, sc_d;
  logic cz_q, cz_d;

  // decode
  wire logic take;
  wire logic is_rot;
  wire logic is_rot_thru;
  wire logic is_sbc;
  wire logic is_inc;
  wire logic is_dec;
  wire logic is_step;
  wire logic is_set;
  wire logic to_mem;
  wire logic to_work;
  wire logic skip_hit;

  // datapath results
  wire logic [XMRS_DATA_W-1:0] rot_res;
  wire logic rot_carry;
  wire logic [XMRS_DATA_W-1:0] sbc_res;
  wire logic sbc_carry;
  wire logic sbc_zero;
  wire logic sbc_nib;
  wire logic sbc_ovf;
  wire logic sbc_sc;
  wire logic sbc_cz;
  wire logic [XMRS_DATA_W-1:0] step_res;
  wire logic [XMRS_DATA_W-1:0] set_res;
  wire logic [XMRS_DATA_W-1:0] result;

  // a request is only taken while the dummy slot is not running
  assign take = op_valid_in & ready_q;

  assign is_rot_thru = (op_code_in == XMRS_OP_ROTATE_RIGHT_THRU_CARRY_MEM)
    | (op_code_in == XMRS_OP_ROTATE_RIGHT_THRU_CARRY_TO_WORK);
  assign is_rot = is_rot_thru
    | (op_code_in == XMRS_OP_ROTATE_RIGHT_MEM)
    | (op_code_in == XMRS_OP_ROTATE_RIGHT_TO_WORK);
  assign is_sbc = (op_code_in == XMRS_OP_SUB_WITH_BORROW_TO_WORK)
    | (op_code_in == XMRS_OP_SUB_WITH_BORROW_TO_MEM);
  assign is_inc = (op_code_in == XMRS_OP_INCREMENT_SKIP_IF_NULL_MEM)
    | (op_code_in == XMRS_OP_INCREMENT_SKIP_IF_NULL_TO_WORK);
  assign is_dec = (op_code_in == XMRS_OP_DECREMENT_SKIP_IF_NULL_MEM)
    | (op_code_in == XMRS_OP_DECREMENT_SKIP_IF_NULL_TO_WORK);
  assign is_step = is_inc | is_dec;
  assign is_set = (op_code_in == XMRS_OP_SET_ALL_OR_ONE_BIT);

  // destination select; the other side is left untouched
  assign to_work = (op_code_in == XMRS_OP_ROTATE_RIGHT_TO_WORK)
    | (op_code_in == XMRS_OP_ROTATE_RIGHT_THRU_CARRY_TO_WORK)
    | (op_code_in == XMRS_OP_SUB_WITH_BORROW_TO_WORK)
    | (op_code_in == XMRS_OP_DECREMENT_SKIP_IF_NULL_TO_WORK)
    | (op_code_in == XMRS_OP_INCREMENT_SKIP_IF_NULL_TO_WORK);
  assign to_mem = (op_code_in == XMRS_OP_ROTATE_RIGHT_MEM)
    | (op_code_in == XMRS_OP_ROTATE_RIGHT_THRU_CARRY_MEM)
    | (op_code_in == XMRS_OP_SUB_WITH_BORROW_TO_MEM)
    | (op_code_in == XMRS_OP_DECREMENT_SKIP_IF_NULL_MEM)
    | (op_code_in == XMRS_OP_INCREMENT_SKIP_IF_NULL_MEM)
    | is_set;

  xmrs_rot u_rot (
    .operand_in(mem_data_in),
    .carry_in(carry_q),
    .thru_carry_in(is_rot_thru),
    .rotated_out(rot_res),
    .carry_out(rot_carry)
  );

  xmrs_sbc u_sbc (
    .minuend_in(work_q),
    .subtrahend_in(mem_data_in),
    .carry_in(carry_q),
    .zero_in(zero_q),
    .diff_out(sbc_res),
    .carry_out(sbc_carry),
    .zero_out(sbc_zero),
    .nibble_carry_out(sbc_nib),
    .signed_range_out(sbc_ovf),
    .signed_carry_out(sbc_sc),
    .chained_null_out(sbc_cz)
  );

  assign step_res = step_byte(mem_data_in, is_inc);
  assign set_res = set_byte(mem_data_in, bit_sel_in, set_single_in);
  assign result = is_rot ? rot_res
    : is_sbc ? sbc_res
    : is_step ? step_res
    : set_res;

  // skip decision on the eight-bit result
  assign skip_hit = take & is_step & (step_res == XMRS_ZERO);

  // working register: op result wins over a direct load
  assign work_d = (take & to_work) ? result
    : (!take & work_load_in) ? work_data_in
    : work_q;

  // rotates through carry touch carry alone, plain rotates nothing
  assign carry_d = (take & is_rot) ? rot_carry
    : (take & is_sbc) ? sbc_carry
    : (!take & flag_load_in) ? carry_data_in
    : carry_q;

  // step, set and rotate leave the five arithmetic flags other than carry alone
  assign zero_d = (take & is_sbc) ? sbc_zero
    : (!take & flag_load_in) ? zero_data_in
    : zero_q;
  assign nib_d = (take & is_sbc) ? sbc_nib
    : (!take & flag_load_in) ? nibble_carry_data_in
    : nib_q;
  assign ovf_d = (take & is_sbc) ? sbc_ovf
    : (!take & flag_load_in) ? signed_range_data_in
    : ovf_q;
  assign sc_d = (take & is_sbc) ? sbc_sc
    : (!take & flag_load_in) ? signed_carry_data_in
    : sc_q;
  assign cz_d = (take & is_sbc) ? sbc_cz
    : (!take & flag_load_in) ? chained_null_data_in
    : cz_q;

  // skipping inserts one dummy slot while the next fetch is dropped
  always_comb begin
    state_d = state_q;
    ready_d = ready_q;
    unique case (state_q)
      XMRS_ST_RUN: begin
        if (skip_hit) begin
          state_d = XMRS_ST_DUMMY;
          ready_d = 1'h0;
        end else begin
          ready_d = 1'h1;
        end
      end
      XMRS_ST_DUMMY: begin
        state_d = XMRS_ST_RUN;
        ready_d = 1'h1;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_q <= XMRS_ST_RUN;
      ready_q <= 1'h0;
    end else begin
      state_q <= state_d;
      ready_q <= ready_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      done_q <= 1'h0;
      skip_q <= 1'h0;
      mem_wr_q <= 1'h0;
      mem_wdata_q <= XMRS_ZERO;
    end else begin
      done_q <= take;
      skip_q <= skip_hit;
      mem_wr_q <= take & to_mem;
      mem_wdata_q <= result;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      work_q <= XMRS_RST_WORK;
      carry_q <= XMRS_RST_FLAG;
      zero_q <= XMRS_RST_FLAG;
      nib_q <= XMRS_RST_FLAG;
      ovf_q <= XMRS_RST_FLAG;
      sc_q <= XMRS_RST_FLAG;
      cz_q <= XMRS_RST_FLAG;
    end else begin
      work_q <= work_d;
      carry_q <= carry_d;
      zero_q <= zero_d;
      nib_q <= nib_d;
      ovf_q <= ovf_d;
      sc_q <= sc_d;
      cz_q <= cz_d;
    end
  end

  // all outputs straight from flops
  assign op_ready_out = ready_q;
  assign done_out = done_q;
  assign skip_out = skip_q;
  assign mem_wr_out = mem_wr_q;
  assign mem_wdata_out = mem_wdata_q;
  assign working_register_out = work_q;
  assign carry_out = carry_q;
  assign zero_out = zero_q;
  assign nibble_carry_out = nib_q;
  assign signed_range_out = ovf_q;
  assign signed_carry_out = sc_q;
  assign chained_null_out = cz_q;
endmodule

// ==== shared/xmrs_pkg.sv ====
package xmrs_pkg;

  // operand geometry
  localparam int unsigned XMRS_DATA_W = 8;
  localparam int unsigned XMRS_BIT_W = 3;
  localparam int unsigned XMRS_MSB = 7;
  localparam int unsigned XMRS_LSB = 0;
  localparam int unsigned XMRS_NIB_W = 4;

  // byte constants
  localparam logic [7:0] XMRS_ALL_ONES = 8'hFF;
  localparam logic [7:0] XMRS_ZERO = 8'h00;
  localparam logic [7:0] XMRS_ONE = 8'h01;

  // reset values
  localparam logic [7:0] XMRS_RST_WORK = 8'h00;
  localparam logic XMRS_RST_FLAG = 1'h0;

  // operations handled by this datapath
  typedef enum logic [3:0] {
    XMRS_OP_ROTATE_RIGHT_MEM,
    XMRS_OP_ROTATE_RIGHT_TO_WORK,
    XMRS_OP_ROTATE_RIGHT_THRU_CARRY_MEM,
    XMRS_OP_ROTATE_RIGHT_THRU_CARRY_TO_WORK,
    XMRS_OP_SUB_WITH_BORROW_TO_WORK,
    XMRS_OP_SUB_WITH_BORROW_TO_MEM,
    XMRS_OP_DECREMENT_SKIP_IF_NULL_MEM,
    XMRS_OP_DECREMENT_SKIP_IF_NULL_TO_WORK,
    XMRS_OP_SET_ALL_OR_ONE_BIT,
    XMRS_OP_INCREMENT_SKIP_IF_NULL_MEM,
    XMRS_OP_INCREMENT_SKIP_IF_NULL_TO_WORK
  } xmrs_op_t;

  // issue sequencer
  typedef enum logic {
    XMRS_ST_RUN,
    XMRS_ST_DUMMY
  } xmrs_state_t;

endpackage

// ==== hdl/xmrs_rot.sv ====
module xmrs_rot (
  // operand
  input wire logic [xmrs_pkg::XMRS_DATA_W-1:0] operand_in,
  input wire logic carry_in,
  input wire logic thru_carry_in,
  // result
  output logic [xmrs_pkg::XMRS_DATA_W-1:0] rotated_out,
  output logic carry_out
);
  import xmrs_pkg::*;

  wire logic fill_bit;

  // plain form feeds bit 0 back, carry form feeds the old carry
  assign fill_bit = thru_carry_in ? carry_in : operand_in[XMRS_LSB];
  assign rotated_out = {fill_bit, operand_in[XMRS_MSB:XMRS_LSB+1]};
  // plain form leaves carry as it was
  assign carry_out = thru_carry_in ? operand_in[XMRS_LSB] : carry_in;
endmodule

// ==== hdl/xmrs_sbc.sv ====
module xmrs_sbc (
  // operands
  input wire logic [xmrs_pkg::XMRS_DATA_W-1:0] minuend_in,
  input wire logic [xmrs_pkg::XMRS_DATA_W-1:0] subtrahend_in,
  input wire logic carry_in,
  input wire logic zero_in,
  // result and flags
  output logic [xmrs_pkg::XMRS_DATA_W-1:0] diff_out,
  output logic carry_out,
  output logic zero_out,
  output logic nibble_carry_out,
  output logic signed_range_out,
  output logic signed_carry_out,
  output logic chained_null_out
);
  import xmrs_pkg::*;

  wire logic [XMRS_DATA_W:0] full_diff;
  wire logic [XMRS_NIB_W:0] nib_diff;
  wire logic borrow_in;

  assign borrow_in = ~carry_in;
  // ninth bit is the borrow out of the byte
  assign full_diff = {1'h0, minuend_in} - {1'h0, subtrahend_in}
    - {8'h00, borrow_in};
  assign nib_diff = {1'h0, minuend_in[XMRS_NIB_W-1:0]}
    - {1'h0, subtrahend_in[XMRS_NIB_W-1:0]} - {4'h0, borrow_in};
  assign diff_out = full_diff[XMRS_DATA_W-1:0];
  // carry clear on negative result, set on zero or positive
  assign carry_out = ~full_diff[XMRS_DATA_W];
  assign nibble_carry_out = ~nib_diff[XMRS_NIB_W];
  assign zero_out = (diff_out == XMRS_ZERO);
  assign signed_range_out = (minuend_in[XMRS_MSB] ^ subtrahend_in[XMRS_MSB])
    & (minuend_in[XMRS_MSB] ^ diff_out[XMRS_MSB]);
  // true sign of the difference, overflow corrected
  assign signed_carry_out = signed_range_out ^ diff_out[XMRS_MSB];
  // lets a compare keep null only if this byte and the zero flag from the previous byte were both null
  assign chained_null_out = zero_out & zero_in;
endmodule

// ==== tb/xmrs_exec_props.sv ====
module xmrs_exec_props
  import xmrs_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // request
  input wire logic op_valid_in,
  input wire xmrs_op_t op_code_in,
  input wire logic [7:0] mem_data_in,
  input wire logic set_single_in,
  // results
  input wire logic op_ready_out,
  input wire logic done_out,
  input wire logic skip_out,
  input wire logic mem_wr_out,
  input wire logic [7:0] mem_wdata_out,
  input wire logic [7:0] working_register_out,
  input wire logic carry_out,
  input wire logic zero_out
);
  logic take;
  assign take = op_valid_in & op_ready_out;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_done_after_take: assert property (take |=> done_out)
    else $error("no done after take");
  a_skip_blocks_issue: assert property (
    skip_out |-> done_out && !op_ready_out ##1 op_ready_out)
    else $error("skip dummy cycle wrong");
  a_rot_mem_value: assert property (
    take && op_code_in == XMRS_OP_ROTATE_RIGHT_MEM |=> mem_wr_out &&
    mem_wdata_out == {$past(mem_data_in[0]), $past(mem_data_in[7:1])} &&
    $stable(carry_out) && $stable(zero_out))
    else $error("rotate to memory wrong");
  a_rot_work_keep: assert property (
    take && op_code_in == XMRS_OP_ROTATE_RIGHT_TO_WORK |=> !mem_wr_out &&
    working_register_out == {$past(mem_data_in[0]),
    $past(mem_data_in[7:1])} && $stable(carry_out))
    else $error("rotate to work wrong");
  a_thru_carry_mem: assert property (
    take && op_code_in == XMRS_OP_ROTATE_RIGHT_THRU_CARRY_MEM |=>
    carry_out == $past(mem_data_in[0]) &&
    mem_wdata_out == {$past(carry_out), $past(mem_data_in[7:1])})
    else $error("carry rotate wrong");
  a_dec_skip_mem: assert property (
    take && op_code_in == XMRS_OP_DECREMENT_SKIP_IF_NULL_MEM |=>
    mem_wr_out && mem_wdata_out == $past(mem_data_in) - 8'h01 &&
    skip_out == (mem_wdata_out == 8'h00))
    else $error("decrement skip wrong");
  a_inc_to_work: assert property (
    take && op_code_in == XMRS_OP_INCREMENT_SKIP_IF_NULL_TO_WORK |=>
    !mem_wr_out && working_register_out == $past(mem_data_in) + 8'h01 &&
    skip_out == (working_register_out == 8'h00))
    else $error("increment to work wrong");
  a_set_all_ones: assert property (
    take && op_code_in == XMRS_OP_SET_ALL_OR_ONE_BIT && !set_single_in |=>
    mem_wr_out && mem_wdata_out == 8'hFF && $stable(zero_out))
    else $error("set all wrong");
endmodule

bind xmrs_exec xmrs_exec_props u_props (.core_clk_in, .sys_rst_in,
  .op_valid_in, .op_code_in, .mem_data_in, .set_single_in,
  .op_ready_out, .done_out,
  .skip_out, .mem_wr_out, .mem_wdata_out, .working_register_out,
  .carry_out, .zero_out);

// ==== tb/xmrs_exec_tb.sv ====
module xmrs_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import xmrs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vld = 1'b0;
  logic sgl = 1'b0;
  logic wld = 1'b0;
  logic fld = 1'b0;
  xmrs_op_t op = XMRS_OP_ROTATE_RIGHT_MEM;
  logic [7:0] md = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [2:0] bs = 3'h0;
  logic [5:0] fd = 6'h00;
  wire rdy, done, skp, mwr;
  wire [7:0] mwd, wr;
  wire [5:0] fl;
  logic [7:0] ew, r;
  logic [5:0] ef;
  logic emw, esk;
  logic [31:0] rv;
  int miscompares = 0;
  int n_tests = 0;
  integer seed = 32'h99d1;

  xmrs_exec u_dut (
    .core_clk_in(clk), .sys_rst_in(rst), .op_valid_in(vld),
    .op_code_in(op), .mem_data_in(md), .bit_sel_in(bs),
    .set_single_in(sgl), .work_load_in(wld), .work_data_in(wd),
    .flag_load_in(fld), .carry_data_in(fd[5]), .zero_data_in(fd[4]),
    .nibble_carry_data_in(fd[3]), .signed_range_data_in(fd[2]),
    .signed_carry_data_in(fd[1]), .chained_null_data_in(fd[0]),
    .op_ready_out(rdy), .done_out(done), .skip_out(skp),
    .mem_wr_out(mwr), .mem_wdata_out(mwd), .working_register_out(wr),
    .carry_out(fl[5]), .zero_out(fl[4]), .nibble_carry_out(fl[3]),
    .signed_range_out(fl[2]), .signed_carry_out(fl[1]),
    .chained_null_out(fl[0])
  );

  initial begin
    forever #5 clk = ~clk;
  end

  task stop_test;
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // random start state goes in through the load ports
  task run(input xmrs_op_t o, input logic [7:0] m, input logic [2:0] b,
           input logic s);
    int i;
    logic [8:0] d;
    logic [4:0] lo;
    logic ov;
    rv = $random(seed);
    wd = rv[7:0];
    fd = rv[13:8];
    wld = 1'b1;
    fld = 1'b1;
    @(negedge clk);
    ew = wd;
    ef = fd;
    // loads held over the take must be ignored, the op wins
    wd = ~ew;
    fd = ~ef;
    for (i = 0; i < 4 && rdy !== 1'b1; i++) @(negedge clk);
    if (rdy !== 1'b1) begin
      miscompares++;
      stop_test;
    end
    op = o;
    md = m;
    bs = b;
    sgl = s;
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    wld = 1'b0;
    fld = 1'b0;
    esk = 1'b0;
    r = {m[0], m[7:1]};
    case (o)
      XMRS_OP_ROTATE_RIGHT_THRU_CARRY_MEM,
      XMRS_OP_ROTATE_RIGHT_THRU_CARRY_TO_WORK: begin
        r[7] = ef[5];
        ef[5] = m[0];
      end
      XMRS_OP_SUB_WITH_BORROW_TO_WORK, XMRS_OP_SUB_WITH_BORROW_TO_MEM: begin
        d = {1'b0, ew} - {1'b0, m} - {8'h00, ~ef[5]};
        lo = {1'b0, ew[3:0]} - {1'b0, m[3:0]} - {4'h0, ~ef[5]};
        ov = (ew[7] != m[7]) && (d[7] != ew[7]);
        r = d[7:0];
        ef = {~d[8], r == 8'h00, ~lo[4], ov, ov ^ r[7],
              (r == 8'h00) & ef[4]};
      end
      XMRS_OP_DECREMENT_SKIP_IF_NULL_MEM,
      XMRS_OP_DECREMENT_SKIP_IF_NULL_TO_WORK: r = m - 8'h01;
      XMRS_OP_INCREMENT_SKIP_IF_NULL_MEM,
      XMRS_OP_INCREMENT_SKIP_IF_NULL_TO_WORK: r = m + 8'h01;
      XMRS_OP_SET_ALL_OR_ONE_BIT:
        r = s ? (m | (8'h01 << b)) : XMRS_ALL_ONES;
      default: ;
    endcase
    if (o inside {XMRS_OP_DECREMENT_SKIP_IF_NULL_MEM,
        XMRS_OP_DECREMENT_SKIP_IF_NULL_TO_WORK,
        XMRS_OP_INCREMENT_SKIP_IF_NULL_MEM,
        XMRS_OP_INCREMENT_SKIP_IF_NULL_TO_WORK})
      esk = (r == 8'h00);
    emw = !(o inside {XMRS_OP_ROTATE_RIGHT_TO_WORK,
        XMRS_OP_ROTATE_RIGHT_THRU_CARRY_TO_WORK,
        XMRS_OP_SUB_WITH_BORROW_TO_WORK,
        XMRS_OP_DECREMENT_SKIP_IF_NULL_TO_WORK,
        XMRS_OP_INCREMENT_SKIP_IF_NULL_TO_WORK});
    if (!emw)
      ew = r;
    chk1(done, 1'b1);
    chk1(mwr, emw);
    chk1(skp, esk);
    chk1(rdy, ~esk);
    if (emw)
      chk8(mwd, r);
    chk8(wr, ew);
    chk8({2'b00, fl}, {2'b00, ef});
    // a request in the dummy cycle must vanish without trace
    if (esk) begin
      op = XMRS_OP_ROTATE_RIGHT_TO_WORK;
      vld = 1'b1;
      @(negedge clk);
      vld = 1'b0;
      chk1(done, 1'b0);
      chk1(rdy, 1'b1);
      chk8(wr, ew);
    end
  endtask

  initial begin
    repeat (20) @(negedge clk);
    chk8(wr, XMRS_RST_WORK);
    chk1(rdy, 1'b0);
    rst = 1'b0;
    run(XMRS_OP_DECREMENT_SKIP_IF_NULL_MEM, 8'h01, 3'h0, 1'b0);
    run(XMRS_OP_DECREMENT_SKIP_IF_NULL_MEM, 8'h00, 3'h0, 1'b0);
    run(XMRS_OP_INCREMENT_SKIP_IF_NULL_MEM, 8'hFF, 3'h0, 1'b0);
    run(XMRS_OP_DECREMENT_SKIP_IF_NULL_TO_WORK, 8'h01, 3'h0, 1'b0);
    run(XMRS_OP_INCREMENT_SKIP_IF_NULL_TO_WORK, 8'hFF, 3'h0, 1'b0);
    run(XMRS_OP_SET_ALL_OR_ONE_BIT, 8'h00, 3'h0, 1'b0);
    for (int k = 0; k < 8; k++)
      run(XMRS_OP_SET_ALL_OR_ONE_BIT, 8'h00, k[2:0], 1'b1);
    for (int k = 0; k < 440; k++) begin
      rv = $random(seed);
      run(xmrs_op_t'(k % 11), rv[7:0], rv[10:8], rv[11]);
    end
    stop_test;
  end
endmodule
